// [verilog/rtif_pkg.sv]
// Constants and types shared by the counter interrupt enable and flag block
package rtif_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] RTIF_IDX_CTRL      = 8'h00;
	localparam logic [7:0] RTIF_IDX_IRQ_CLR   = 8'h06;
	localparam logic [7:0] RTIF_IDX_IRQ_SET   = 8'h07;
	localparam logic [7:0] RTIF_IDX_IRQ_FLAG  = 8'h08;
	localparam logic [7:0] RTIF_IDX_STATUS    = 8'h0A;

	// Bit positions shared by enable and flag registers
	localparam int RTIF_BIT_WRAP      = 7;
	localparam int RTIF_BIT_SYNC_DONE = 6;
	localparam int RTIF_BIT_MATCH_ONE = 1;
	localparam int RTIF_BIT_MATCH_ZERO = 0;

	// Status register: sync in progress
	localparam int RTIF_BIT_SYNC_BUSY = 7;

	// Control register fields
	localparam int RTIF_BIT_SWRST     = 0;
	localparam int RTIF_BIT_ENABLE    = 1;
	localparam int RTIF_POS_MODE      = 2;

	// Used bits per mode
	localparam logic [7:0] RTIF_MASK_ONE_MATCH = 8'hC1;
	localparam logic [7:0] RTIF_MASK_TWO_MATCH = 8'hC3;

	// Reset values
	localparam logic [7:0]  RTIF_RST_REG8  = 8'h00;
	localparam logic [31:0] RTIF_RST_RDATA = 32'h0000_0000;

	// AHB encodings
	localparam logic [1:0] RTIF_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] RTIF_HTRANS_SEQ    = 2'h3;
	localparam logic       RTIF_HRESP_OKAY    = 1'h0;

	typedef enum logic [1:0] {
		COUNT32_MODE,
		COUNT16_MODE,
		CALENDAR_MODE,
		RESERVED_MODE
	} rtif_mode_t;

endpackage : rtif_pkg

// [verilog/rtif_irq.sv]
// Interrupt enable set/clear and flag logic of the counter, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none

module rtif_irq (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic [31:0]       hrdata,
	output logic              hresp,
	input  wire logic         counter_clock,
	input  wire logic         counter_wrap,
	input  wire logic [1:0]   compare_match_n,
	input  wire logic         alarm_match_zero,
	input  wire logic         sync_in_progress,
	output rtif_pkg::rtif_mode_t counter_mode,
	output logic              counter_enable,
	output logic              soft_reset,
	output logic              irq
);
	import rtif_pkg::*;

	typedef struct packed {
		rtif_mode_t  mode;
		logic        run;
		logic        swrst;
		logic [7:0]  enables;
		logic [7:0]  flags;
		logic [7:0]  pend;
		logic        busy_seen;
		logic        suppress;
		logic        wr_pend;
		logic [7:0]  wr_idx;
		logic [31:0] rdata;
		logic        ready;
		logic        irq;
	} rtif_state_t;

	rtif_state_t st_reg;
	rtif_state_t st_next;

	// Bits that are in use for a mode
	function automatic logic [7:0] used_mask(input rtif_mode_t m);
		logic [7:0] r;
		r = RTIF_MASK_ONE_MATCH;
		case (m)
			COUNT16_MODE: r = RTIF_MASK_TWO_MATCH;
			default: r = RTIF_MASK_ONE_MATCH;
		endcase
		return r;
	endfunction : used_mask

	// Word index from a byte address; off-word addresses map nowhere
	function automatic logic [7:0] word_idx(input logic [31:0] a);
		logic [7:0] r;
		r = 8'hFF;
		if ((a[31:10] == 22'h00_0000) && (a[1:0] == 2'h0)) begin
			r = a[9:2];
		end
		return r;
	endfunction : word_idx

	always_comb begin
		logic [7:0] mask;
		logic [7:0] ev;
		logic [7:0] set_bits;
		logic [7:0] clr_bits;
		logic [7:0] wdat;
		logic       wr_ctrl;
		logic       rd_go;
		logic [7:0] rd_idx;
		logic       busy_fall;
		mask      = used_mask(st_reg.mode);
		ev        = 8'h00;
		set_bits  = 8'h00;
		clr_bits  = 8'h00;
		wdat      = hwdata[7:0];
		wr_ctrl   = 1'b0;
		rd_go     = 1'b0;
		rd_idx    = 8'hFF;
		busy_fall = 1'b0;
		st_next   = st_reg;
		st_next.swrst = 1'b0;

		// Counter-domain events, steered by mode
		ev[RTIF_BIT_WRAP] = counter_wrap;
		if (st_reg.mode == CALENDAR_MODE) begin
			ev[RTIF_BIT_MATCH_ZERO] = alarm_match_zero;
		end else begin
			ev[RTIF_BIT_MATCH_ZERO] = compare_match_n[0];
		end
		if (st_reg.mode == COUNT16_MODE) begin
			ev[RTIF_BIT_MATCH_ONE] = compare_match_n[1];
		end

		// Event seen on one tick lands in the flag on the next tick
		if (counter_clock) begin
			set_bits = st_reg.pend & mask;
			st_next.pend = ev & mask;
		end

		// Sync done: falling busy, unless a change of the enable bit or a soft reset started it
		st_next.busy_seen = sync_in_progress;
		busy_fall = st_reg.busy_seen & ~sync_in_progress;
		if (busy_fall) begin
			if (!st_reg.suppress) begin
				set_bits[RTIF_BIT_SYNC_DONE] = 1'b1;
			end
			st_next.suppress = 1'b0;
		end

		// Data phase of a write taken last cycle
		if (st_reg.wr_pend) begin
			case (st_reg.wr_idx)
				RTIF_IDX_IRQ_SET: begin
					st_next.enables = st_reg.enables | (wdat & mask);
				end
				RTIF_IDX_IRQ_CLR: begin
					st_next.enables = st_reg.enables & ~wdat;
				end
				RTIF_IDX_IRQ_FLAG: begin
					clr_bits = wdat;
				end
				RTIF_IDX_CTRL: begin
					wr_ctrl = 1'b1;
				end
				default: begin
					wr_ctrl = 1'b0;
				end
			endcase
		end

		// Hardware set wins over a software clear in the same cycle
		st_next.flags = ((st_reg.flags & ~clr_bits) | set_bits) & mask;

		if (wr_ctrl) begin
			if (wdat[RTIF_BIT_SWRST]) begin
				// Soft reset returns mode, run, enables, flags and pend to reset values; its sync is not reported
				st_next.swrst    = 1'b1;
				st_next.mode     = COUNT32_MODE;
				st_next.run      = 1'b0;
				st_next.enables  = RTIF_RST_REG8;
				st_next.flags    = RTIF_RST_REG8;
				st_next.pend     = RTIF_RST_REG8;
				st_next.suppress = 1'b1;
			end else begin
				if (wdat[RTIF_BIT_ENABLE] != st_reg.run) begin
					st_next.suppress = 1'b1;
				end
				st_next.run  = wdat[RTIF_BIT_ENABLE];
				st_next.mode = rtif_mode_t'(wdat[RTIF_POS_MODE +: 2]);
				// Mode change drops bits the new mode does not use
				st_next.enables = st_next.enables & used_mask(rtif_mode_t'(wdat[RTIF_POS_MODE +: 2]));
				st_next.flags   = st_next.flags & used_mask(rtif_mode_t'(wdat[RTIF_POS_MODE +: 2]));
			end
		end

		// Address phase
		st_next.wr_pend = 1'b0;
		if (hsel && hready && ((htrans == RTIF_HTRANS_NONSEQ) || (htrans == RTIF_HTRANS_SEQ))) begin
			if (hwrite) begin
				st_next.wr_pend = 1'b1;
				st_next.wr_idx  = word_idx(haddr);
			end else begin
				rd_go  = 1'b1;
				rd_idx = word_idx(haddr);
			end
		end

		// Read data from next state, so a write just before is visible
		if (rd_go) begin
			st_next.rdata = RTIF_RST_RDATA;
			case (rd_idx)
				RTIF_IDX_IRQ_SET, RTIF_IDX_IRQ_CLR: begin
					st_next.rdata[7:0] = st_next.enables;
				end
				RTIF_IDX_IRQ_FLAG: begin
					st_next.rdata[7:0] = st_next.flags;
				end
				RTIF_IDX_STATUS: begin
					st_next.rdata[RTIF_BIT_SYNC_BUSY] = sync_in_progress;
				end
				RTIF_IDX_CTRL: begin
					st_next.rdata[RTIF_BIT_ENABLE] = st_next.run;
					st_next.rdata[RTIF_POS_MODE +: 2] = st_next.mode;
				end
				default: begin
					st_next.rdata = RTIF_RST_RDATA;
				end
			endcase
		end

		st_next.ready = 1'b1;
		st_next.irq   = |(st_next.flags & st_next.enables & used_mask(st_next.mode));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hreadyout      = st_reg.ready;
	assign hrdata         = st_reg.rdata;
	assign hresp          = RTIF_HRESP_OKAY;
	assign counter_mode   = st_reg.mode;
	assign counter_enable = st_reg.run;
	assign soft_reset     = st_reg.swrst;
	assign irq            = st_reg.irq;

endmodule : rtif_irq

`default_nettype wire

// [verif/rtif_irq_sva.sv]
// Assertion checker for the counter interrupt block
`timescale 1ns/1ps
`default_nettype none
module rtif_irq_sva (
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire logic                 hsel,
	input wire logic [31:0]          haddr,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic                 hready,
	input wire logic                 hreadyout,
	input wire logic [31:0]          hrdata,
	input wire logic                 hresp,
	input wire logic                 counter_clock,
	input wire logic                 sync_in_progress,
	input wire rtif_pkg::rtif_mode_t counter_mode,
	input wire logic                 soft_reset,
	input wire logic                 irq
);
	import rtif_pkg::*;
	logic wr_dp;
	// Write data phase marker; registers change at its closing edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_dp <= 1'b0;
		end else begin
			wr_dp <= hsel && hready && htrans[1] && hwrite;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd(logic [31:0] a);
		hsel && hready && htrans[1] && !hwrite && haddr == a;
	endsequence
	property p_ready; $past(hresetn) |-> hreadyout && hresp == RTIF_HRESP_OKAY; endproperty
	property p_status; s_rd(32'h0000_0028) |=> hrdata[7] == $past(sync_in_progress); endproperty
	property p_unmapped; s_rd(32'h0000_002C) |=> hrdata == RTIF_RST_RDATA; endproperty
	property p_upper; s_rd(haddr) |=> hrdata[31:8] == 24'h00_0000; endproperty
	property p_irq_fall; $fell(irq) |-> $past(wr_dp) || $past(soft_reset); endproperty
	property p_irq_rise;
		$rose(irq) |-> $past(counter_clock) || $past(wr_dp) || ($past(sync_in_progress, 2) && !$past(sync_in_progress));
	endproperty
	property p_swrst; soft_reset |=> !soft_reset; endproperty
	property p_mode; !$stable(counter_mode) |-> $past(wr_dp) || $past(soft_reset); endproperty
	a_ready: assert property (p_ready) else $error("bus not ready or not okay");
	a_status: assert property (p_status) else $error("status busy bit wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_upper: assert property (p_upper) else $error("upper read bits not zero");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
	a_swrst: assert property (p_swrst) else $error("soft reset not one cycle");
	a_mode: assert property (p_mode) else $error("mode changed without write");
endmodule : rtif_irq_sva
bind rtif_irq rtif_irq_sva i_rtif_irq_sva (.*);
`default_nettype wire

// [verif/rtif_irq_tb.sv]
// Testbench for the counter interrupt block
`timescale 1ns/1ps
`default_nettype none
module rtif_irq_tb;
	import rtif_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, counter_clock, counter_wrap, alarm_match_zero, sync_in_progress;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, compare_match_n;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, counter_enable, soft_reset, irq;
	wire logic   hready;
	rtif_mode_t  counter_mode;
	int          n_mismatch, check_count;
	logic [7:0]  exp_a [3] = '{8'h01, 8'h03, 8'h00};
	logic [7:0]  exp_b [3] = '{8'h01, 8'h03, 8'h01};
	logic [7:0]  msk [3] = '{RTIF_MASK_ONE_MATCH, RTIF_MASK_TWO_MATCH, RTIF_MASK_ONE_MATCH};
	assign hready = hreadyout;
	rtif_irq i_rtif_irq (.*);
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			n_mismatch++;
		end
	endtask : chk
	// Both transfers hold every signal until hready is seen at an edge
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
		haddr <= a;
		hwrite <= w;
		htrans <= RTIF_HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		if (!w) chk("hrdata", e, hrdata);
	endtask : xfer
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0);
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, e);
	endtask : rd
	// Event in one tick, then a second tick that lets the flag land
	task automatic ev(input logic w, input logic [1:0] c, input logic al);
		counter_clock <= 1'b1;
		counter_wrap <= w;
		compare_match_n <= c;
		alarm_match_zero <= al;
		@(posedge hclk);
		counter_wrap <= 1'b0;
		compare_match_n <= 2'h0;
		alarm_match_zero <= 1'b0;
		@(posedge hclk);
		counter_clock <= 1'b0;
		@(posedge hclk);
	endtask : ev
	task automatic sync_pulse;
		sync_in_progress <= 1'b1;
		repeat (3) @(posedge hclk);
		sync_in_progress <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask : sync_pulse
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (5000) @(posedge hclk);
		n_mismatch++;
		close_out();
	end
	initial begin
		{hresetn, hwrite, counter_clock, counter_wrap, alarm_match_zero, sync_in_progress} = 6'h00;
		{haddr, hwdata, htrans, compare_match_n} = 68'h0;
		hsel = 1'b1;
		hsize = 3'h2;
		n_mismatch = 0;
		check_count = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int a = 6; a < 12; a++) rd(32'(a * 4), 32'h0);
		$display("test reset done");
		wr(32'h1C, 32'h00);
		rd(32'h1C, 32'h00);
		wr(32'h1C, 32'h80);
		rd(32'h18, 32'h80);
		ev(1'b1, 2'h0, 1'b0);
		chk("irq", 32'h1, irq);
		rd(32'h20, 32'h80);
		wr(32'h20, 32'h00);
		rd(32'h20, 32'h80);
		wr(32'h20, 32'h80);
		// Irq drops at the write's closing edge, so look one edge later
		@(posedge hclk);
		chk("irq", 32'h0, irq);
		wr(32'h18, 32'hFF);
		rd(32'h1C, 32'h00);
		$display("test wrap done");
		for (int m = 0; m < 3; m++) begin
			wr(32'h00, 32'(m) << 2);
			rd(32'h00, 32'(m) << 2);
			chk("counter_mode", 32'(m), counter_mode);
			wr(32'h1C, 32'hFF);
			rd(32'h1C, {24'h0, msk[m]});
			ev(1'b0, 2'h3, 1'b0);
			rd(32'h20, {24'h0, exp_a[m]});
			ev(1'b0, 2'h0, 1'b1);
			rd(32'h20, {24'h0, exp_b[m]});
			chk("irq", 32'h1, irq);
			wr(32'h20, 32'hFF);
			wr(32'h18, 32'hFF);
			rd(32'h1C, 32'h00);
			rd(32'h20, 32'h00);
		end
		$display("test modes done");
		wr(32'h1C, 32'h40);
		sync_pulse();
		rd(32'h28, 32'h00);
		rd(32'h20, 32'h40);
		chk("irq", 32'h1, irq);
		wr(32'h20, 32'h40);
		wr(32'h00, 32'h01);
		// Soft reset pulse stands for the cycle after the write
		@(posedge hclk);
		chk("soft_reset", 32'h1, soft_reset);
		sync_pulse();
		rd(32'h20, 32'h00);
		sync_pulse();
		rd(32'h20, 32'h40);
		wr(32'h20, 32'h40);
		wr(32'h00, 32'h02);
		rd(32'h00, 32'h02);
		chk("counter_enable", 32'h1, counter_enable);
		// A fall after enabling is not reported
		sync_pulse();
		rd(32'h20, 32'h00);
		$display("test sync done");
		close_out();
	end
endmodule : rtif_irq_tb
`default_nettype wire
